//--- src/txseg_host.sv
// Purpose: stream source driving the segmented transmit port of the MAC
// Assumes: i_clk is the transmit clock handed out by the MAC
// Notes: user beats pass a two-entry buffer before reaching the MAC
//
// Functional notes
// - drop valid at once while ready low
// - only valid-high cycles carry any transfer
// - two independent 8-byte segments, either boundary
// - segment moves only with enable and valid
// - at most one frame start per cycle
// - at most one frame end per cycle
// - empty count gives unused trailing bytes
// - empty count zero outside end cycle
// - bad flag only on final transfer
// - keep feeding every ready cycle in frame
// - active-high synchronous reset held until stable
`timescale 1ns/1ps
`default_nettype none
`include "txseg_regs.svh"

module txseg_host (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // user side beat, segment zero
  input wire logic i_usr_valid,
  output logic o_usr_ready,
  input wire logic [`TXSEG_SEG_W-1:0] i_usr_segment_zero_data,
  input wire logic i_usr_segment_zero_enable,
  input wire logic i_usr_segment_zero_frame_start,
  input wire logic i_usr_segment_zero_frame_end,
  input wire logic i_usr_segment_zero_bad_frame,
  input wire logic [`TXSEG_MTY_W-1:0] i_usr_segment_zero_empty_bytes,
  // user side beat, segment one
  input wire logic [`TXSEG_SEG_W-1:0] i_usr_segment_one_data,
  input wire logic i_usr_segment_one_enable,
  input wire logic i_usr_segment_one_frame_start,
  input wire logic i_usr_segment_one_frame_end,
  input wire logic i_usr_segment_one_bad_frame,
  input wire logic [`TXSEG_MTY_W-1:0] i_usr_segment_one_empty_bytes,
  // user side status
  input wire logic i_clear_underflow,
  output logic o_format_error,
  output logic o_starved,
  output logic o_underflow_seen,
  output logic o_frame_open,
  // MAC transmit port
  output logic o_tx_reset,
  input wire logic i_tx_ready,
  input wire logic i_tx_underflow,
  output logic o_tx_valid,
  output logic [`TXSEG_DATA_W-1:0] o_tx_data,
  output logic o_segment_zero_enable,
  output logic o_segment_one_enable,
  output logic o_segment_zero_frame_start,
  output logic o_segment_one_frame_start,
  output logic o_segment_zero_frame_end,
  output logic o_segment_one_frame_end,
  output logic o_segment_zero_bad_frame,
  output logic o_segment_one_bad_frame,
  output logic [`TXSEG_MTY_W-1:0] o_segment_zero_empty_bytes,
  output logic [`TXSEG_MTY_W-1:0] o_segment_one_empty_bytes
);

  // a segment counts only with its enable and the bus valid
  function automatic logic seg_live(input logic valid, input logic ena);
    seg_live = valid & ena;
  endfunction

  // frame state after one segment: a start opens, an end closes
  function automatic txseg_pkg::frame_e frame_step(
    input txseg_pkg::frame_e cur,
    input logic sop,
    input logic eop
  );
    frame_step = cur;
    if (sop) begin
      frame_step = txseg_pkg::FRAME_OPEN;
    end
    if (eop) begin
      frame_step = txseg_pkg::FRAME_IDLE;
    end
  endfunction

  // gather user inputs per segment; segment zero holds earlier bytes
  // the MAC reads segment one as the later half of the word
  wire logic [`TXSEG_NSEG-1:0] u_ena;
  wire logic [`TXSEG_NSEG-1:0] u_sop;
  wire logic [`TXSEG_NSEG-1:0] u_eop;
  wire logic [`TXSEG_NSEG-1:0] u_err;
  wire logic [`TXSEG_NSEG*`TXSEG_MTY_W-1:0] u_mty;
  wire logic [`TXSEG_DATA_W-1:0] u_data;
  assign u_ena = {i_usr_segment_one_enable, i_usr_segment_zero_enable};
  assign u_sop = {i_usr_segment_one_frame_start,
                  i_usr_segment_zero_frame_start};
  assign u_eop = {i_usr_segment_one_frame_end, i_usr_segment_zero_frame_end};
  assign u_err = {i_usr_segment_one_bad_frame, i_usr_segment_zero_bad_frame};
  assign u_mty = {i_usr_segment_one_empty_bytes,
                  i_usr_segment_zero_empty_bytes};
  assign u_data = {i_usr_segment_one_data, i_usr_segment_zero_data};

  // clean each segment: flags only where enabled, extras cleared
  // stray flags on an idle segment would upset the MAC framing
  wire logic [`TXSEG_NSEG-1:0] c_sop;
  wire logic [`TXSEG_NSEG-1:0] c_eop;
  wire logic [`TXSEG_NSEG-1:0] c_err;
  wire logic [`TXSEG_NSEG-1:0] c_ena;
  wire logic [`TXSEG_NSEG*`TXSEG_MTY_W-1:0] c_mty;
  genvar s;
  generate
    for (s = 0; s < `TXSEG_NSEG; s = s + 1) begin : g_seg
      assign c_ena[s] = seg_live(i_usr_valid, u_ena[s]);
      assign c_eop[s] = c_ena[s] & u_eop[s];
      assign c_err[s] = c_eop[s] & u_err[s];
      // empty count only on the end segment, else all bytes valid
      assign c_mty[s*`TXSEG_MTY_W +: `TXSEG_MTY_W] = c_eop[s] ?
        u_mty[s*`TXSEG_MTY_W +: `TXSEG_MTY_W] : `TXSEG_MTY_NONE;
    end
  endgenerate

  // one start per beat: a second start in segment one is dropped
  // keeping segment zero keeps the earlier frame whole
  wire logic two_sop;
  wire logic two_eop;
  assign two_sop = seg_live(i_usr_valid, u_ena[0]) & u_sop[0] &
                   seg_live(i_usr_valid, u_ena[1]) & u_sop[1];
  assign two_eop = c_eop[0] & c_eop[1];
  assign c_sop[0] = c_ena[0] & u_sop[0];
  assign c_sop[1] = c_ena[1] & u_sop[1] & ~two_sop;

  // any end in segment one is dropped when segment zero also ends
  // the user still sees the drop through the format pulse
  wire logic [`TXSEG_NSEG-1:0] k_eop;
  wire logic [`TXSEG_NSEG-1:0] k_err;
  wire logic [`TXSEG_NSEG*`TXSEG_MTY_W-1:0] k_mty;
  assign k_eop = {c_eop[1] & ~two_eop, c_eop[0]};
  assign k_err = {c_err[1] & ~two_eop, c_err[0]};
  assign k_mty = {two_eop ? `TXSEG_MTY_NONE :
                  c_mty[`TXSEG_MTY_W +: `TXSEG_MTY_W],
                  c_mty[`TXSEG_MTY_W-1:0]};

  // cleaned beat as it enters the buffer
  txseg_pkg::beat_s in_beat;
  assign in_beat.data = u_data;
  assign in_beat.ena = c_ena;
  assign in_beat.sop = c_sop;
  assign in_beat.eop = k_eop;
  assign in_beat.err = k_err;
  assign in_beat.mty = k_mty;

  // two-entry buffer bookkeeping
  // two entries let the MAC drop ready without losing a user beat
  txseg_pkg::beat_s buf_q [`TXSEG_DEPTH];
  logic [`TXSEG_PTR_W-1:0] wr_q;
  logic [`TXSEG_PTR_W-1:0] rd_q;
  logic [`TXSEG_CNT_W-1:0] cnt_q;
  wire logic buf_full;
  wire logic buf_has;
  wire logic push;
  wire logic pop;
  assign buf_full = (cnt_q == `TXSEG_CNT_W'(`TXSEG_DEPTH));
  assign buf_has = (cnt_q != `TXSEG_CNT_W'(0));
  assign o_usr_ready = ~buf_full & ~o_tx_reset;
  assign push = i_usr_valid & o_usr_ready & (|c_ena);
  assign pop = buf_has & i_tx_ready;

  // buffer storage, written only at the write index
  // stale entries are harmless: the fill level says what is live
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else if (push) begin
      buf_q[wr_q] <= in_beat;
    end
  end

  // buffer pointers and fill level
  // one-bit pointers wrap by themselves over the two entries
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_q + `TXSEG_PTR_W'(push);
      rd_q <= rd_q + `TXSEG_PTR_W'(pop);
      cnt_q <= cnt_q + `TXSEG_CNT_W'(push) - `TXSEG_CNT_W'(pop);
    end
  end

  // head beat toward the MAC; valid falls with ready at once
  // valid is combinational so a ready drop stops the beat in time
  txseg_pkg::beat_s head;
  assign head = buf_q[rd_q];
  assign o_tx_valid = pop;
  assign o_tx_data = head.data;
  assign o_segment_zero_enable = head.ena[0];
  assign o_segment_one_enable = head.ena[1];
  assign o_segment_zero_frame_start = head.sop[0];
  assign o_segment_one_frame_start = head.sop[1];
  assign o_segment_zero_frame_end = head.eop[0];
  assign o_segment_one_frame_end = head.eop[1];
  assign o_segment_zero_bad_frame = head.err[0];
  assign o_segment_one_bad_frame = head.err[1];
  assign o_segment_zero_empty_bytes = head.mty[`TXSEG_MTY_W-1:0];
  assign o_segment_one_empty_bytes = head.mty[`TXSEG_MTY_W +: `TXSEG_MTY_W];

  // frame state after each beat the MAC takes, segment zero first
  // a beat may close one frame and open the next
  txseg_pkg::frame_e frame_q;
  txseg_pkg::frame_e frame_d;
  txseg_pkg::frame_e mid_state;
  always_comb begin
    mid_state = frame_step(frame_q, head.sop[0], head.eop[0]);
    frame_d = frame_q;
    if (pop) begin
      frame_d = frame_step(mid_state, head.sop[1], head.eop[1]);
    end
  end

  // ready cycle inside a frame with nothing to send
  // the user must keep the buffer fed while a frame is open
  wire logic starve_now;
  assign starve_now = (frame_q == txseg_pkg::FRAME_OPEN) & i_tx_ready &
                      ~buf_has;

  // user-side violation seen on an accepted beat
  // a beat held back by a full buffer is not counted yet
  wire logic fmt_now;
  assign fmt_now = i_usr_valid & o_usr_ready & (two_sop | two_eop);

  // status: frame state, pulses, sticky MAC underflow
  logic starved_q;
  logic fmt_q;
  logic unf_q;

  // frame state advances only on beats the MAC takes
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      frame_q <= txseg_pkg::FRAME_IDLE;
    end else begin
      frame_q <= frame_d;
    end
  end

  // starvation flag, high after each idle ready cycle in a frame
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      starved_q <= 1'b0;
    end else begin
      starved_q <= starve_now;
    end
  end

  // format pulse after a beat that lost a second start or a second end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fmt_q <= 1'b0;
    end else begin
      fmt_q <= fmt_now;
    end
  end

  // sticky MAC underflow; a new underflow beats the clear
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      unf_q <= 1'b0;
    end else begin
      unf_q <= i_tx_underflow | (unf_q & ~i_clear_underflow);
    end
  end
  assign o_starved = starved_q;
  assign o_format_error = fmt_q;
  assign o_underflow_seen = unf_q;
  assign o_frame_open = (frame_q == txseg_pkg::FRAME_OPEN);

  // MAC reset: high during ours, then held a few cycles more
  // the MAC wants a synchronous reset, so this comes from a flop
  logic [`TXSEG_RST_CNT_W-1:0] rst_cnt_q;
  logic tx_rst_q;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rst_cnt_q <= '0;
      tx_rst_q <= 1'b1;
    end else if (tx_rst_q) begin
      rst_cnt_q <= rst_cnt_q + `TXSEG_RST_CNT_W'(1);
      tx_rst_q <= (rst_cnt_q !=
                   `TXSEG_RST_CNT_W'(`TXSEG_RST_HOLD_CYC - 1));
    end
  end
  assign o_tx_reset = tx_rst_q;

endmodule
`default_nettype wire

//--- common/txseg_regs.svh
// Purpose: constants for the segmented transmit stream source
// Assumes: one clock at 100 MHz, period 10 ns
// Notes: source widths, counts and the reset hold time live here
`ifndef TXSEG_REGS_SVH
`define TXSEG_REGS_SVH

// bus geometry
`define TXSEG_NSEG 2
`define TXSEG_SEG_BYTES 8
`define TXSEG_SEG_W 64
`define TXSEG_DATA_W 128
`define TXSEG_MTY_W 3
`define TXSEG_MTY_NONE 3'h0

// two-entry buffer
`define TXSEG_DEPTH 2
`define TXSEG_CNT_W 2
`define TXSEG_PTR_W 1

// reset hold toward the device after our own reset lifts
`define TXSEG_CLK_PERIOD_NS 10
`define TXSEG_RST_HOLD_NS 100
`define TXSEG_RST_HOLD_CYC \
  ((`TXSEG_RST_HOLD_NS + `TXSEG_CLK_PERIOD_NS - 1) / `TXSEG_CLK_PERIOD_NS)
`define TXSEG_RST_CNT_W 4

`endif

//--- common/txseg_pkg.sv
// Purpose: types for the segmented transmit stream source
// Assumes: constants come from txseg_regs.svh
// Notes: one buffered beat holds both segments
`include "txseg_regs.svh"

package txseg_pkg;

  // one beat of both segments, already cleaned up
  typedef struct packed {
    logic [`TXSEG_DATA_W-1:0] data;
    logic [`TXSEG_NSEG-1:0] ena;
    logic [`TXSEG_NSEG-1:0] sop;
    logic [`TXSEG_NSEG-1:0] eop;
    logic [`TXSEG_NSEG-1:0] err;
    logic [`TXSEG_NSEG*`TXSEG_MTY_W-1:0] mty;
  } beat_s;

  // frame tracking on the device side
  typedef enum logic {
    FRAME_IDLE,
    FRAME_OPEN
  } frame_e;

endpackage

//--- verification/txseg_host_checker.sv
// Purpose: MAC-side protocol checks for the stream source
// Assumes: one clock, async active-high reset
// Notes: attached by bind below the module
`timescale 1ns/1ps
`default_nettype none
`include "txseg_regs.svh"

module txseg_host_checker (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // MAC port
  input wire logic i_tx_ready,
  input wire logic o_tx_valid,
  input wire logic o_tx_reset,
  input wire logic o_usr_ready,
  input wire logic [`TXSEG_DATA_W-1:0] o_tx_data,
  input wire logic o_segment_zero_enable,
  input wire logic o_segment_zero_frame_start,
  input wire logic o_segment_one_frame_start,
  input wire logic o_segment_zero_frame_end,
  input wire logic o_segment_one_frame_end,
  input wire logic o_segment_zero_bad_frame,
  input wire logic [`TXSEG_MTY_W-1:0] o_segment_one_empty_bytes
);
  // one clock domain
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // handshake and framing of each offered beat, and the reset hold
  ready_gates_a: assert property (o_tx_valid |-> i_tx_ready)
    else $error("valid while not ready");
  full_hold_a: assert property (!i_tx_ready && !o_usr_ready &&
    !o_tx_reset |=> $stable(o_tx_data)) else $error("head moved");
  one_start_a: assert property (o_tx_valid |->
    !(o_segment_zero_frame_start && o_segment_one_frame_start))
    else $error("two starts");
  one_end_a: assert property (o_tx_valid |->
    !(o_segment_zero_frame_end && o_segment_one_frame_end))
    else $error("two ends");
  empty_at_end_a: assert property (o_tx_valid &&
    !o_segment_one_frame_end |-> o_segment_one_empty_bytes == 3'h0)
    else $error("empty count off end");
  bad_at_end_a: assert property (o_tx_valid &&
    o_segment_zero_bad_frame |-> o_segment_zero_frame_end)
    else $error("bad flag off end");
  start_enabled_a: assert property (o_tx_valid &&
    o_segment_zero_frame_start |-> o_segment_zero_enable)
    else $error("start without enable");
  reset_hold_a: assert property ($fell(i_rst) |->
    (o_tx_reset && !o_usr_ready) [*8]) else $error("reset hold short");
endmodule

bind txseg_host txseg_host_checker chk (.*);
`default_nettype wire

//--- verification/txseg_mac_model.sv
// Purpose: behavioural MAC transmit port
// Assumes: reset input is the source's reset toward the MAC
// Notes: flags are {ena1,ena0,sop1,sop0,eop1,eop0,bad1,bad0}
`timescale 1ns/1ps
`default_nettype none

module txseg_mac_model (
  // clock, reset, pacing
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_stall,
  // stream from the source
  input wire logic i_valid,
  input wire logic [127:0] i_data,
  input wire logic [7:0] i_flags,
  input wire logic [5:0] i_empty,
  // answers and last taken beat
  output logic o_ready,
  output logic o_underflow,
  output logic o_errored,
  output logic [127:0] o_data,
  output logic [7:0] o_flags,
  output logic [5:0] o_empty
);
  logic open_q;
  logic take;
  logic any_end;
  // ready only while not stalled and out of reset
  assign o_ready = !i_rst && !i_stall;
  // a transfer needs valid and an enable
  assign take = i_valid && o_ready && |i_flags[7:6];
  assign any_end = |i_flags[3:2];
  // a gap inside an open frame starves the line
  assign o_underflow = open_q && o_ready && !i_valid;
  // synchronous reset, inputs sampled on the rising edge
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      open_q <= 1'b0;
      o_errored <= 1'b0;
      o_empty <= 6'h00;
    end else if (take) begin
      o_data <= i_data;
      o_flags <= i_flags;
      open_q <= (i_flags[5] && !i_flags[3]) ||
        ((i_flags[4] || open_q) && !any_end);
      // bad counts only at an enabled end, per frame
      if (any_end) begin
        o_errored <= |(i_flags[1:0] & i_flags[3:2] &
          i_flags[7:6]);
        // empty count only means something at an end
        o_empty <= i_empty;
      end
    end
  end
endmodule
`default_nettype wire

//--- verification/segmented_tx_packet_stream_test.sv
// Purpose: self-checking bench for the stream source
// Assumes: 100 MHz clock, behavioural MAC
// Notes: flag vectors as in the MAC model
`timescale 1ns/1ps
`default_nettype none
`include "txseg_regs.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  fails++; $display("Error %s expected %0h seen %0h", n, e, g); end end

module segmented_tx_packet_stream_test;
  logic i_clk = 0, i_rst = 1, i_usr_valid = 0, i_clear_underflow = 0;
  logic stall = 0;
  logic [7:0] uf = 0, cap_flags;
  logic [5:0] um = 0;
  logic [127:0] ud = 0, cap_data;
  logic cap_err;
  logic [5:0] cap_empty;
  int fails = 0, checks_done = 0, n;
  wire logic i_tx_ready, i_tx_underflow, o_usr_ready, o_format_error;
  wire logic o_starved, o_underflow_seen, o_frame_open, o_tx_reset;
  wire logic o_tx_valid, o_segment_zero_enable, o_segment_one_enable;
  wire logic o_segment_zero_frame_start, o_segment_one_frame_start;
  wire logic o_segment_zero_frame_end, o_segment_one_frame_end;
  wire logic o_segment_zero_bad_frame, o_segment_one_bad_frame;
  wire logic [2:0] o_segment_zero_empty_bytes, o_segment_one_empty_bytes;
  wire logic [127:0] o_tx_data;
  wire logic [63:0] i_usr_segment_zero_data, i_usr_segment_one_data;
  wire logic i_usr_segment_zero_enable, i_usr_segment_one_enable;
  wire logic i_usr_segment_zero_frame_start, i_usr_segment_one_frame_start;
  wire logic i_usr_segment_zero_frame_end, i_usr_segment_one_frame_end;
  wire logic i_usr_segment_zero_bad_frame, i_usr_segment_one_bad_frame;
  wire logic [2:0] i_usr_segment_zero_empty_bytes;
  wire logic [2:0] i_usr_segment_one_empty_bytes;
  // user beat unpacked from the scenario vectors
  assign {i_usr_segment_one_enable, i_usr_segment_zero_enable,
    i_usr_segment_one_frame_start, i_usr_segment_zero_frame_start,
    i_usr_segment_one_frame_end, i_usr_segment_zero_frame_end,
    i_usr_segment_one_bad_frame, i_usr_segment_zero_bad_frame} = uf;
  assign {i_usr_segment_one_empty_bytes,
    i_usr_segment_zero_empty_bytes} = um;
  assign {i_usr_segment_one_data, i_usr_segment_zero_data} = ud;
  txseg_host DUT (.*);
  txseg_mac_model mac (.i_clk, .i_rst(o_tx_reset), .i_stall(stall),
    .i_valid(o_tx_valid), .i_data(o_tx_data),
    .i_flags({o_segment_one_enable, o_segment_zero_enable,
    o_segment_one_frame_start, o_segment_zero_frame_start,
    o_segment_one_frame_end, o_segment_zero_frame_end,
    o_segment_one_bad_frame, o_segment_zero_bad_frame}),
    .o_ready(i_tx_ready), .o_underflow(i_tx_underflow),
    .i_empty({o_segment_one_empty_bytes, o_segment_zero_empty_bytes}),
    .o_errored(cap_err), .o_data(cap_data), .o_flags(cap_flags),
    .o_empty(cap_empty));
  always #5 i_clk = ~i_clk;
  task give_verdict;
    if (fails == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // offer one beat, return at the edge that takes it
  task put(input logic [7:0] f, input logic [5:0] m, input logic [127:0] d);
    @(negedge i_clk);
    uf = f;
    um = m;
    ud = d;
    i_usr_valid = 1'b1;
    for (n = 0; n < 40 && o_usr_ready !== 1'b1; n++) @(negedge i_clk);
    @(posedge i_clk);
  endtask
  // stop offering and let the pipe drain
  task rest(input int c);
    @(negedge i_clk);
    i_usr_valid = 1'b0;
    repeat (c) @(negedge i_clk);
  endtask
  // reset toward the MAC stays up for the hold count
  task t_reset;
    @(negedge i_clk);
    i_rst = 1'b0;
    for (n = 0; n < 40 && o_tx_reset === 1'b1; n++) begin
      `CHK("usr_ready", 1'b0, o_usr_ready)
      @(negedge i_clk);
    end
    `CHK("hold", `TXSEG_RST_HOLD_CYC, n)
  endtask
  // stalled MAC: two beats fill the buffer, the third waits
  task t_fill;
    stall = 1'b1;
    put(8'hD0, 6'h00, 128'h1);
    put(8'hC0, 6'h00, 128'h2);
    @(negedge i_clk);
    `CHK("full", 1'b0, o_usr_ready)
    `CHK("tx_valid", 1'b0, o_tx_valid)
    @(negedge i_clk);
    `CHK("held", 1'b0, o_tx_valid)
    stall = 1'b0;
    put(8'hC8, 6'h10, {64'hB, 64'hA});
    rest(4);
    `CHK("flags", 8'hC8, cap_flags)
    `CHK("data", {64'hB, 64'hA}, cap_data)
    `CHK("empty", 6'h10, cap_empty)
    `CHK("open", 1'b0, o_frame_open)
    `CHK("under", 1'b0, o_underflow_seen)
  endtask
  // two starts and two ends in one beat, bad end corrupts
  task t_fmt;
    put(8'hFF, 6'h3F, 128'h5);
    rest(0);
    `CHK("format", 1'b1, o_format_error)
    rest(3);
    `CHK("cut", 8'hD5, cap_flags)
    `CHK("cut_empty", 6'h07, cap_empty)
    `CHK("errored", 1'b1, cap_err)
  endtask
  // gap inside a frame; bad flag off the end is dropped
  task t_under;
    put(8'h51, 6'h3F, 128'h7);
    rest(3);
    `CHK("mid", 8'h50, cap_flags)
    `CHK("underflow", 1'b1, o_underflow_seen)
    `CHK("starved", 1'b1, o_starved)
    put(8'h44, 6'h00, 128'h8);
    rest(2);
    `CHK("fed", 1'b0, o_starved)
    i_clear_underflow = 1'b1;
    rest(0);
    i_clear_underflow = 1'b0;
    `CHK("cleared", 1'b0, o_underflow_seen)
    `CHK("good", 1'b0, cap_err)
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge i_clk);
    t_reset;
    t_fill;
    t_fmt;
    t_under;
    give_verdict;
  end
  // hang guard, far past the few dozen cycles used
  initial begin
    #20000;
    fails++;
    give_verdict;
  end
endmodule
`default_nettype wire
